//--- verilog/cmt_defs.vh
`ifndef CMT_DEFS_VH
`define CMT_DEFS_VH

// Register byte addresses on the APB.
`define CMT_OFS_CTRL      8'h00
`define CMT_OFS_ABS_CYC   8'h04
`define CMT_OFS_ABS_OFS   8'h08
`define CMT_OFS_DUAL_CFG0 8'h0c
`define CMT_OFS_DUAL_CFG1 8'h10
`define CMT_OFS_INT_STAT  8'h14
`define CMT_OFS_INT_EN    8'h18
`define CMT_OFS_INT_CLR   8'h1c

// Control register bit positions.
`define CMT_BIT_DUAL_TB    13
`define CMT_BIT_DUAL_REP   12
`define CMT_BIT_DUAL_STOP  10
`define CMT_BIT_DUAL_START 9
`define CMT_BIT_DUAL_RUN   8
`define CMT_BIT_ABS_REP    4
`define CMT_BIT_ABS_STOP   2
`define CMT_BIT_ABS_START  1
`define CMT_BIT_ABS_RUN    0

// Cycle filter field positions.
`define CMT_CYC_VAL_HI 13
`define CMT_CYC_VAL_LO 8
`define CMT_CYC_MSK_HI 5
`define CMT_CYC_MSK_LO 0
// Macrotick offset field.
`define CMT_MT_HI 13
`define CMT_MT_LO 0

// Interrupt status bit positions.
`define CMT_INT_ABS  0
`define CMT_INT_DUAL 1

// Reset values.
`define CMT_RST_CTRL 16'h0000
`define CMT_RST_CYC  16'h0000
`define CMT_RST_OFS  16'h0000
`define CMT_RST_DCFG 16'h0000
`define CMT_RST_INT  2'h0

`endif

//--- verilog/cmt_abs_match.v
`timescale 1ns/10ps
`include "cmt_defs.vh"

module cmt_abs_match (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire        run,
	input  wire        tick,
	input  wire [5:0]  cycleCount,
	input  wire [13:0] macrotick,
	input  wire [5:0]  cycVal,
	input  wire [5:0]  cycMsk,
	input  wire [13:0] mtOffset,
	output reg         hit
);

	// Only mask positions set to one take part in the cycle compare.
	function maskedEq;
		input [5:0] a;
		input [5:0] b;
		input [5:0] m;
		begin
			maskedEq = ((a & m) == (b & m));
		end
	endfunction

	// Compared live against the registers, so a rewrite acts at once.
	always @(posedge clock) begin
		if (sys_rst) begin
			hit <= 1'b0;
		end else begin
			hit <= run & tick & maskedEq(cycleCount, cycVal, cycMsk) & (macrotick == mtOffset);
		end
	end

endmodule

//--- verilog/cmt_rel_count.v
`timescale 1ns/10ps

module cmt_rel_count (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire        load,
	input  wire        run,
	input  wire        tick,
	input  wire [31:0] value,
	output reg         hit
);

	reg [31:0] count_r;

	// Counts down macroticks; the reload value is sampled only at start and
	// at expiry, so a rewrite while running waits for the current expiry.
	always @(posedge clock) begin
		if (sys_rst) begin
			count_r <= 32'h00000000;
			hit     <= 1'b0;
		end else if (load) begin
			count_r <= value;
			hit     <= 1'b0;
		end else if (run & tick) begin
			if (count_r <= 32'h00000001) begin
				count_r <= value;
				hit     <= 1'b1;
			end else begin
				count_r <= count_r - 32'h00000001;
				hit     <= 1'b0;
			end
		end else begin
			hit <= 1'b0;
		end
	end

endmodule

//--- verilog/cmt_timer_ctrl.v
`timescale 1ns/10ps
`include "cmt_defs.vh"

module cmt_timer_ctrl (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [5:0]  cycleCount,
	input  wire [13:0] macrotick,
	input  wire        macrotickTick,
	input  wire        pocNormal,
	output reg         absTimerExpired,
	output reg         dualTimerExpired,
	output reg         irq
);

////////////////////////////////////////////////////////////////////////////////
// Register state.

	// Trigger bits have no storage: they act on the write and read as zero.
	// The running flags and status bits are the only state hardware changes itself.
	reg        dualTimebaseSel_r;
	reg        dualRepeatEn_r;
	reg        absRepeatEn_r;
	reg        absRunning_r;
	reg        absRunning_nxt;
	reg        dualRunning_r;
	reg        dualRunning_nxt;
	reg [5:0]  absCycVal_r;
	reg [5:0]  absCycMsk_r;
	reg [13:0] absOffset_r;
	reg [15:0] dualCfg0_r;
	reg [15:0] dualCfg1_r;
	reg [1:0]  intStatus_r;
	reg [1:0]  intEnable_r;
	reg [31:0] readData;
	reg        addrHit;

	// Hit lines come from registered comparators and are single-cycle pulses.
	wire       absHit;
	wire       dualAbsHit;
	wire       dualRelHit;
	wire       dualHit;
	// Write strobes are high only in the commit cycle of an access.
	wire       busWrite;
	wire       ctrlWrite;
	wire       absStart;
	wire       absStop;
	wire       dualStart;
	wire       dualStop;
	wire [1:0] intSet;
	wire [1:0] intClr;

	// Reset images of the registers; fields are cut out by position so that a
	// changed reset value in the header reaches every field at once.
	localparam [15:0] CTRL_RST = `CMT_RST_CTRL;
	localparam [15:0] CYC_RST  = `CMT_RST_CYC;
	localparam [15:0] OFS_RST  = `CMT_RST_OFS;

	// Address decode for the error answer; the read mux decodes with its own case.
	// Only the eight aligned word offsets answer; anything else is an error.
	function isMapped;
		input [7:0] a;
		begin
			isMapped = (a == `CMT_OFS_CTRL) | (a == `CMT_OFS_ABS_CYC) |
				(a == `CMT_OFS_ABS_OFS) | (a == `CMT_OFS_DUAL_CFG0) |
				(a == `CMT_OFS_DUAL_CFG1) | (a == `CMT_OFS_INT_STAT) |
				(a == `CMT_OFS_INT_EN) | (a == `CMT_OFS_INT_CLR);
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// APB slave.

	// One wait state: pready rises on the first access cycle's edge, so the
	// transfer completes on the second access edge and read data is ready.
	// The fixed wait state costs a cycle per access but lets the read mux settle
	// from a stable address, which keeps the slave's timing simple.
	always @(posedge clock) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addrHit;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= readData;
			end
		end
	end

	// A write takes effect only on the completing edge of the access phase.
	// Writes to unmapped addresses fall into no register and are dropped.
	assign busWrite  = psel & penable & pready & pwrite;
	assign ctrlWrite = busWrite & (paddr == `CMT_OFS_CTRL);

	// Trigger bits act only when written as one; zeros leave timers alone.
	// If stop and start are both written as one, stop wins further down.
	assign absStart  = ctrlWrite & pwdata[`CMT_BIT_ABS_START];
	assign absStop   = ctrlWrite & pwdata[`CMT_BIT_ABS_STOP];
	assign dualStart = ctrlWrite & pwdata[`CMT_BIT_DUAL_START];
	assign dualStop  = ctrlWrite & pwdata[`CMT_BIT_DUAL_STOP];

	// Read mux; trigger bits and reserved bits read as zero.
	// The running bits are read-only; a write to them is ignored.
	always @* begin
		addrHit  = isMapped(paddr);
		readData = 32'h00000000;
		case (paddr)
			`CMT_OFS_CTRL: begin
				readData[`CMT_BIT_DUAL_TB]  = dualTimebaseSel_r;
				readData[`CMT_BIT_DUAL_REP] = dualRepeatEn_r;
				readData[`CMT_BIT_DUAL_RUN] = dualRunning_r;
				readData[`CMT_BIT_ABS_REP]  = absRepeatEn_r;
				readData[`CMT_BIT_ABS_RUN]  = absRunning_r;
			end
			`CMT_OFS_ABS_CYC: begin
				readData[`CMT_CYC_VAL_HI:`CMT_CYC_VAL_LO] = absCycVal_r;
				readData[`CMT_CYC_MSK_HI:`CMT_CYC_MSK_LO] = absCycMsk_r;
			end
			`CMT_OFS_ABS_OFS: begin
				readData[`CMT_MT_HI:`CMT_MT_LO] = absOffset_r;
			end
			`CMT_OFS_DUAL_CFG0: begin
				readData[15:0] = dualCfg0_r;
			end
			`CMT_OFS_DUAL_CFG1: begin
				readData[15:0] = dualCfg1_r;
			end
			`CMT_OFS_INT_STAT: begin
				readData[1:0] = intStatus_r;
			end
			`CMT_OFS_INT_EN: begin
				readData[1:0] = intEnable_r;
			end
			`CMT_OFS_INT_CLR: begin
				readData = 32'h00000000; // Write-only, so it reads as zero.
			end
			default: begin
				readData = 32'h00000000;
			end
		endcase
	end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers.

	// Filter and offset fields feed the comparators directly, with no shadow
	// copy, so a rewrite while a timer runs is seen on the very next tick.
	// A write to the dual-mode words while the relative count runs only changes
	// the reload value; the counter takes it at its next expiry or start.
	always @(posedge clock) begin
		if (sys_rst) begin
			dualTimebaseSel_r <= CTRL_RST[`CMT_BIT_DUAL_TB];
			dualRepeatEn_r    <= CTRL_RST[`CMT_BIT_DUAL_REP];
			absRepeatEn_r     <= CTRL_RST[`CMT_BIT_ABS_REP];
			absCycVal_r       <= CYC_RST[`CMT_CYC_VAL_HI:`CMT_CYC_VAL_LO];
			absCycMsk_r       <= CYC_RST[`CMT_CYC_MSK_HI:`CMT_CYC_MSK_LO];
			absOffset_r       <= OFS_RST[`CMT_MT_HI:`CMT_MT_LO];
			dualCfg0_r        <= `CMT_RST_DCFG;
			dualCfg1_r        <= `CMT_RST_DCFG;
			intEnable_r       <= `CMT_RST_INT;
		end else if (busWrite) begin
			case (paddr)
				`CMT_OFS_CTRL: begin
					dualTimebaseSel_r <= pwdata[`CMT_BIT_DUAL_TB];
					dualRepeatEn_r    <= pwdata[`CMT_BIT_DUAL_REP];
					absRepeatEn_r     <= pwdata[`CMT_BIT_ABS_REP];
				end
				`CMT_OFS_ABS_CYC: begin
					absCycVal_r <= pwdata[`CMT_CYC_VAL_HI:`CMT_CYC_VAL_LO];
					absCycMsk_r <= pwdata[`CMT_CYC_MSK_HI:`CMT_CYC_MSK_LO];
				end
				`CMT_OFS_ABS_OFS: begin
					absOffset_r <= pwdata[`CMT_MT_HI:`CMT_MT_LO];
				end
				`CMT_OFS_DUAL_CFG0: begin
					dualCfg0_r <= pwdata[15:0];
				end
				`CMT_OFS_DUAL_CFG1: begin
					dualCfg1_r <= pwdata[15:0];
				end
				`CMT_OFS_INT_EN: begin
					intEnable_r <= pwdata[1:0];
				end
				`CMT_OFS_INT_STAT: begin
					intEnable_r <= intEnable_r; // Status is read-only; writes are dropped.
				end
				`CMT_OFS_INT_CLR: begin
					intEnable_r <= intEnable_r; // Clearing is handled with the status bits.
				end
				default: begin
					intEnable_r <= intEnable_r;
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Expiry detection.

	// The absolute timer only ever uses the cycle and macrotick compare.
	// Matches are sampled on the tick edge, so a hit lags the tick by one cycle.
	cmt_abs_match absMatch (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.run        (absRunning_r),
		.tick       (macrotickTick),
		.cycleCount (cycleCount),
		.macrotick  (macrotick),
		.cycVal     (absCycVal_r),
		.cycMsk     (absCycMsk_r),
		.mtOffset   (absOffset_r),
		.hit        (absHit)
	);

	// Dual-mode absolute compare uses the same field layout in its registers.
	cmt_abs_match dualMatch (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.run        (dualRunning_r & ~dualTimebaseSel_r),
		.tick       (macrotickTick),
		.cycleCount (cycleCount),
		.macrotick  (macrotick),
		.cycVal     (dualCfg0_r[`CMT_CYC_VAL_HI:`CMT_CYC_VAL_LO]),
		.cycMsk     (dualCfg0_r[`CMT_CYC_MSK_HI:`CMT_CYC_MSK_LO]),
		.mtOffset   (dualCfg1_r[`CMT_MT_HI:`CMT_MT_LO]),
		.hit        (dualAbsHit)
	);

	// Relative count is the two config words, high word first.
	// The reload value is taken only at start and at expiry, so software may
	// rewrite both words while it runs without tearing the count in progress.
	cmt_rel_count dualCount (
		.clock   (clock),
		.sys_rst (sys_rst),
		.load    (dualStart),
		.run     (dualRunning_r & dualTimebaseSel_r),
		.tick    (macrotickTick),
		.value   ({dualCfg0_r, dualCfg1_r}),
		.hit     (dualRelHit)
	);

	// Timebase bit low selects the absolute compare, high the counter.
	// Switching the timebase while running also stops the unselected compare; the counter holds its count.
	assign dualHit = dualTimebaseSel_r ? dualRelHit : dualAbsHit;

////////////////////////////////////////////////////////////////////////////////
// Running state.

	// Priority: protocol exit, then stop, then start, then expiry. A hit is
	// ignored if the timer was stopped meanwhile, so no stale event escapes.
	// Limitation: a start while running restarts the timer rather than being
	// refused, which reloads the relative count from the current configuration.
	always @* begin
		absRunning_nxt = absRunning_r;
		if (!pocNormal) begin
			absRunning_nxt = 1'b0;
		end else if (absStop) begin
			absRunning_nxt = 1'b0;
		end else if (absStart) begin
			absRunning_nxt = 1'b1;
		end else if (absHit & ~absRepeatEn_r) begin
			absRunning_nxt = 1'b0;
		end
	end

	// Same ordering for the dual-mode timer.
	// Stop beats start when both are written in one access.
	always @* begin
		dualRunning_nxt = dualRunning_r;
		if (!pocNormal) begin
			dualRunning_nxt = 1'b0;
		end else if (dualStop) begin
			dualRunning_nxt = 1'b0;
		end else if (dualStart) begin
			dualRunning_nxt = 1'b1;
		end else if (dualHit & ~dualRepeatEn_r) begin
			dualRunning_nxt = 1'b0;
		end
	end

	// Running flags and registered expiry pulses.
	// Expiry pulses are gated by the flag of the previous cycle and by the
	// protocol state, so nothing escapes after a stop or a protocol exit.
	always @(posedge clock) begin
		if (sys_rst) begin
			absRunning_r     <= 1'b0;
			dualRunning_r    <= 1'b0;
			absTimerExpired  <= 1'b0;
			dualTimerExpired <= 1'b0;
		end else begin
			absRunning_r     <= absRunning_nxt;
			dualRunning_r    <= dualRunning_nxt;
			absTimerExpired  <= absHit & absRunning_r & pocNormal;
			dualTimerExpired <= dualHit & dualRunning_r & pocNormal;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Interrupts.

	// Sticky event bits; a set in the clearing cycle wins so no event is lost.
	// Both events share one interrupt line; software reads the status word to
	// tell them apart.
	assign intSet = {dualTimerExpired, absTimerExpired};
	assign intClr = (busWrite & (paddr == `CMT_OFS_INT_CLR)) ? pwdata[1:0] : 2'h0;

	// The interrupt line is computed from the next status value, so it follows
	// a clear or a new event with one cycle of lag only.
	always @(posedge clock) begin
		if (sys_rst) begin
			intStatus_r <= `CMT_RST_INT;
			irq         <= 1'b0;
		end else begin
			intStatus_r <= (intStatus_r & ~intClr) | intSet;
			irq         <= |(((intStatus_r & ~intClr) | intSet) & intEnable_r);
		end
	end

endmodule

//--- sim/cmt_timer_ctrl_properties.sv
`timescale 1ns/10ps
`include "cmt_defs.vh"
module cmt_timer_ctrl_props (
	input wire        clock,
	input wire        sys_rst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [5:0]  cycleCount,
	input wire [13:0] macrotick,
	input wire        macrotickTick,
	input wire        pocNormal,
	input wire        absTimerExpired,
	input wire        dualTimerExpired,
	input wire        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// One setup cycle, then exactly one wait state before the answer.
	sequence s_setup; psel && !penable; endsequence
	sequence s_wait; psel && penable && !pready ##1 psel && penable && pready; endsequence
	property p_apb; s_setup |=> s_wait; endproperty
	a_apb: assert property (p_apb) else $error("bus answer late or early");
	property p_rdy_qual; pready |-> psel && penable ##1 !pready; endproperty
	a_rdy_qual: assert property (p_rdy_qual) else $error("ready outside access");
	property p_err_map; pready |-> pslverr == ((paddr > `CMT_OFS_INT_CLR) || (paddr[1:0] != 2'h0)); endproperty
	a_err_map: assert property (p_err_map) else $error("slave error wrong");
	property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_err_data: assert property (p_err_data) else $error("unmapped read data");
	property p_upper; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	// Expiry is only judged on a macrotick update, two cycles earlier.
	property p_tick; absTimerExpired || dualTimerExpired |-> $past(macrotickTick, 2); endproperty
	a_tick: assert property (p_tick) else $error("expiry without tick");
	property p_poc_gate; !pocNormal |=> !absTimerExpired && !dualTimerExpired; endproperty
	a_poc_gate: assert property (p_poc_gate) else $error("expiry outside normal");
	property p_irq_off;
		pready && pwrite && paddr == `CMT_OFS_INT_EN && pwdata[1:0] == 2'h0 |=> ##1 !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked interrupt stays");
endmodule
bind cmt_timer_ctrl cmt_timer_ctrl_props i_cmt_timer_ctrl_props (.clock(clock), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cycleCount(cycleCount), .macrotick(macrotick),
	.macrotickTick(macrotickTick), .pocNormal(pocNormal), .absTimerExpired(absTimerExpired),
	.dualTimerExpired(dualTimerExpired), .irq(irq));

//--- sim/test_cmt_timer_ctrl.sv
`timescale 1ns/10ps
`include "cmt_defs.vh"
module test_cmt_timer_ctrl;
	reg            clock, sys_rst, psel, penable, pwrite, macrotickTick, pocNormal, e;
	reg     [7:0]  paddr;
	reg     [31:0] pwdata, r;
	reg     [5:0]  cycleCount;
	reg     [13:0] macrotick;
	wire    [31:0] prdata;
	wire           pready, pslverr, absTimerExpired, dualTimerExpired, irq;
	integer        mismatches = 0, n_compared = 0, nAbs = 0, nDual = 0;
	cmt_timer_ctrl i_cmt_timer_ctrl (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cycleCount(cycleCount), .macrotick(macrotick), .macrotickTick(macrotickTick),
		.pocNormal(pocNormal), .absTimerExpired(absTimerExpired), .dualTimerExpired(dualTimerExpired),
		.irq(irq));
	////////////////////////////////////////
	// Free running 40 MHz clock.
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Count expiry pulses so a scenario can judge a whole window.
	always @(posedge clock) begin
		if (absTimerExpired === 1'b1) nAbs = nAbs + 1;
		if (dualTimerExpired === 1'b1) nDual = nDual + 1;
	end
	task chk(input string nm, input [31:0] s, input [31:0] x);
		n_compared = n_compared + 1;
		if (s !== x) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0s expected %h seen %h", nm, x, s);
		end
	endtask
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One APB transfer; the request is held until pready is sampled high.
	task apb(input w, input [7:0] a, input [15:0] d);
		integer n;
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clock);
			n = n + 1;
		end
		if (n >= 20) begin
			mismatches = mismatches + 1;
			finish_test;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task wr(input [7:0] a, input [15:0] d); apb(1'b1, a, d); endtask
	task rd(input [7:0] a); apb(1'b0, a, 16'h0000); endtask
	// One macrotick update, then enough cycles for the two-cycle expiry pipeline.
	task tk(input [13:0] m, input [5:0] c, input integer ea, input integer ed);
		nAbs = 0;
		nDual = 0;
		@(posedge clock);
		macrotick <= m; cycleCount <= c; macrotickTick <= 1'b1;
		@(posedge clock);
		macrotickTick <= 1'b0;
		repeat (3) @(posedge clock);
		chk("abs_hits", nAbs, ea);
		chk("dual_hits", nDual, ed);
	endtask
	////////////////////////////////////////
	task t_regs;
		rd(`CMT_OFS_CTRL); chk("ctrl_rst", r, 0);
		wr(`CMT_OFS_ABS_CYC, 16'h2a15); rd(`CMT_OFS_ABS_CYC); chk("cyc", r, 32'h2a15);
		wr(`CMT_OFS_ABS_OFS, 16'h3fff); rd(`CMT_OFS_ABS_OFS); chk("ofs", r, 32'h3fff);
		rd(8'h20); chk("bad_err", e, 1); chk("bad_data", r, 0);
		wr(8'h20, 16'hffff); chk("bad_wr_err", e, 1);
	endtask
	task t_abs;
		wr(`CMT_OFS_ABS_CYC, 16'h053f); wr(`CMT_OFS_ABS_OFS, 16'h0010); wr(`CMT_OFS_CTRL, 16'h0002);
		rd(`CMT_OFS_CTRL); chk("abs_run", r[0], 1);
		wr(`CMT_OFS_CTRL, 16'h0000); rd(`CMT_OFS_CTRL); chk("abs_run", r[0], 1);
		tk(14'h0010, 6'h06, 0, 0);
		tk(14'h0011, 6'h05, 0, 0);
		tk(14'h0010, 6'h05, 1, 0);
		rd(`CMT_OFS_CTRL); chk("abs_run", r[0], 0);
		wr(`CMT_OFS_INT_EN, 16'h0001); rd(`CMT_OFS_INT_STAT); chk("stat", r, 1); chk("irq", irq, 1);
		wr(`CMT_OFS_INT_EN, 16'h0000); rd(`CMT_OFS_INT_STAT); chk("stat", r, 1); chk("irq", irq, 0);
		wr(`CMT_OFS_INT_EN, 16'h0001); wr(`CMT_OFS_INT_CLR, 16'h0001);
		rd(`CMT_OFS_INT_STAT); chk("stat", r, 0); chk("irq", irq, 0);
	endtask
	// Filter and offset rewrites must act on a running timer at once.
	task t_live;
		wr(`CMT_OFS_CTRL, 16'h0012); wr(`CMT_OFS_ABS_OFS, 16'h0020);
		tk(14'h0010, 6'h05, 0, 0);
		tk(14'h0020, 6'h05, 1, 0);
		wr(`CMT_OFS_ABS_CYC, 16'h0730);
		tk(14'h0020, 6'h05, 1, 0);
		tk(14'h0020, 6'h15, 0, 0);
		rd(`CMT_OFS_CTRL); chk("abs_run", r[0], 1);
		wr(`CMT_OFS_CTRL, 16'h0014); rd(`CMT_OFS_CTRL); chk("abs_run", r[0], 0);
		wr(`CMT_OFS_CTRL, 16'h0016); rd(`CMT_OFS_CTRL); chk("abs_stop_wins", r[0], 0);
		tk(14'h0020, 6'h05, 0, 0);
	endtask
	task t_dual;
		wr(`CMT_OFS_DUAL_CFG0, 16'h0000); wr(`CMT_OFS_DUAL_CFG1, 16'h0040); wr(`CMT_OFS_CTRL, 16'h0200);
		rd(`CMT_OFS_CTRL); chk("dual_run", r[8], 1);
		tk(14'h0040, 6'h09, 0, 1);
		wr(`CMT_OFS_DUAL_CFG1, 16'h0003); wr(`CMT_OFS_CTRL, 16'h2200);
		repeat (2) tk(14'h0001, 6'h00, 0, 0);
		tk(14'h0002, 6'h00, 0, 1);
		rd(`CMT_OFS_CTRL); chk("dual_run", r[8], 0);
		wr(`CMT_OFS_CTRL, 16'h3200);
		repeat (2) tk(14'h0001, 6'h00, 0, 0);
		tk(14'h0002, 6'h00, 0, 1);
		wr(`CMT_OFS_CTRL, 16'h3000); rd(`CMT_OFS_CTRL); chk("dual_run", r[8], 1);
		wr(`CMT_OFS_CTRL, 16'h3400); rd(`CMT_OFS_CTRL); chk("dual_run", r[8], 0);
		rd(`CMT_OFS_INT_STAT); chk("stat_dual", r[1], 1);
	endtask
	// Leaving normal operation kills both timers and blocks restarts.
	task t_poc;
		wr(`CMT_OFS_CTRL, 16'h1212);
		@(posedge clock);
		pocNormal <= 1'b0;
		rd(`CMT_OFS_CTRL); chk("both_run", {r[8], r[0]}, 0);
		wr(`CMT_OFS_CTRL, 16'h0202); rd(`CMT_OFS_CTRL); chk("both_run", {r[8], r[0]}, 0);
		tk(14'h0020, 6'h05, 0, 0);
		pocNormal <= 1'b1;
	endtask
	////////////////////////////////////////
	// Reset for 20 cycles, then walk the scenarios.
	initial begin
		sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		cycleCount = 6'h00; macrotick = 14'h0000; macrotickTick = 1'b0; pocNormal = 1'b1;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs;
		t_abs;
		t_live;
		t_dual;
		t_poc;
		finish_test;
	end
endmodule
